// ### verilog/emb_bus_ctrl.sv
// External program and data memory bus controller
`timescale 1ns/100ps
module emb_bus_ctrl #(
  parameter int unsigned OSC_DIV = emb_pkg::OSC_DIV_DEF
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic external_code_select_n,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic code_ext,
  output logic fetch_ack,
  output logic [7:0] fetch_data,
  input wire logic data_req,
  input emb_pkg::emb_data_cmd_t data_cmd,
  output logic data_ack,
  output logic [7:0] data_rdata,
  input wire logic [7:0] low_port_latch,
  input wire logic [7:0] high_port_latch,
  output logic [7:0] low_port_value,
  output logic [7:0] high_port_value,
  output logic download_mode,
  input wire logic [7:0] low_addr_data_port_i,
  output logic [7:0] low_addr_data_port_o,
  output logic [7:0] low_addr_data_port_oe,
  input wire logic [7:0] high_addr_port_i,
  output logic [7:0] high_addr_port_o,
  output logic [7:0] high_addr_port_oe,
  input wire logic program_fetch_strobe_n_i,
  output logic program_fetch_strobe_n_o,
  output logic program_fetch_strobe_n_oe,
  output logic addr_latch_strobe,
  output logic data_read_strobe_n,
  output logic data_write_strobe_n
);

  localparam int unsigned DW = $clog2(OSC_DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(OSC_DIV - 1);

  // Divider and synchroniser latency need two cycles per period
  if (OSC_DIV < emb_pkg::OSC_DIV_MIN || OSC_DIV > emb_pkg::OSC_DIV_MAX)
  begin : g_chk
    $error("OSC_DIV out of range");
  end

  emb_pkg::emb_state_t state_r;
  logic [3:0] phase_r;
  logic [DW-1:0] div_r;
  logic [2:0] strap_cnt_r;
  logic [23:0] addr_r;
  logic we_r;
  logic [7:0] wdata_r;
  logic osc_en;
  logic slot_end;
  logic ea_s;
  logic program_fetch_strobe_n_s;
  logic [7:0] low_s;
  logic [7:0] high_s;
  logic bus_en;
  emb_pkg::emb_port_drv_t low_drv;
  emb_pkg::emb_port_drv_t high_drv;
  logic ale_c;
  logic program_fetch_strobe_n_c;
  logic rd_c;
  logic wr_c;

  // Pins come from outside the clock domain
  emb_sync #(
    .W(18)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({external_code_select_n, program_fetch_strobe_n_i,
        low_addr_data_port_i, high_addr_port_i}),
    .q({ea_s, program_fetch_strobe_n_s, low_s, high_s})
  );

  assign code_ext = !ea_s || (fetch_addr > emb_pkg::INT_CODE_TOP);

  // Oscillator period enable, held during the strap window
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      div_r <= '0;
    end else if (state_r == emb_pkg::EMB_ST_STRAP || div_r == DIV_LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign osc_en = (state_r != emb_pkg::EMB_ST_STRAP) && (div_r == DIV_LAST);
  assign slot_end = osc_en && (phase_r == ((state_r == emb_pkg::EMB_ST_DATA)
                    ? emb_pkg::PH_DATA_LAST : emb_pkg::PH_SLOT_LAST));

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      strap_cnt_r <= 3'h0;
    end else if (state_r == emb_pkg::EMB_ST_STRAP) begin
      strap_cnt_r <= strap_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      download_mode <= 1'b0;
    end else if (state_r == emb_pkg::EMB_ST_STRAP &&
                 strap_cnt_r == emb_pkg::STRAP_LAST) begin
      download_mode <= !program_fetch_strobe_n_s;
    end
  end

  // Slot sequencer; data requests win over fetches
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= emb_pkg::EMB_ST_STRAP;
      phase_r <= 4'h0;
    end else begin
      case (state_r)
        emb_pkg::EMB_ST_STRAP: begin
          if (strap_cnt_r == emb_pkg::STRAP_LAST) begin
            state_r <= emb_pkg::EMB_ST_IDLE;
          end
        end
        emb_pkg::EMB_ST_IDLE, emb_pkg::EMB_ST_FETCH,
        emb_pkg::EMB_ST_DATA: begin
          if (slot_end) begin
            phase_r <= 4'h0;
            if (data_req) begin
              state_r <= emb_pkg::EMB_ST_DATA;
            end else if (fetch_req && code_ext) begin
              state_r <= emb_pkg::EMB_ST_FETCH;
            end else begin
              state_r <= emb_pkg::EMB_ST_IDLE;
            end
          end else if (osc_en) begin
            phase_r <= phase_r + 4'h1;
          end
        end
        default: begin
          state_r <= emb_pkg::EMB_ST_STRAP;
          phase_r <= 4'h0;
        end
      endcase
    end
  end

  // Request captured at the slot boundary
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      addr_r <= emb_pkg::ADDR_RST;
      we_r <= 1'b0;
      wdata_r <= emb_pkg::BYTE_RST;
    end else if (slot_end && data_req) begin
      addr_r <= data_cmd.addr;
      we_r <= data_cmd.we;
      wdata_r <= data_cmd.wdata;
    end else if (slot_end && fetch_req && code_ext) begin
      addr_r <= {8'h00, fetch_addr};
      we_r <= 1'b0;
    end
  end

  // Strobe and port drive for the current phase
  always_comb begin
    bus_en = 1'b0;
    low_drv = '0;
    high_drv = '0;
    ale_c = 1'b0;
    program_fetch_strobe_n_c = 1'b1;
    rd_c = 1'b1;
    wr_c = 1'b1;
    case (state_r)
      emb_pkg::EMB_ST_FETCH: begin
        bus_en = 1'b1;
        ale_c = (phase_r == emb_pkg::PH_ALE);
        if (phase_r <= emb_pkg::PH_ADDR_LAST) begin
          low_drv.o = addr_r[7:0];
          low_drv.oe = 8'hFF;
        end
        high_drv.o = addr_r[15:8];
        high_drv.oe = 8'hFF;
        program_fetch_strobe_n_c = !(phase_r >= emb_pkg::PH_FETCH_FIRST &&
                   phase_r <= emb_pkg::PH_FETCH_LAST);
      end
      emb_pkg::EMB_ST_DATA: begin
        bus_en = 1'b1;
        // no second strobe in a data slot
        ale_c = (phase_r == emb_pkg::PH_ALE);
        // page byte beside the low byte
        high_drv.oe = 8'hFF;
        if (phase_r <= emb_pkg::PH_ADDR_LAST) begin
          high_drv.o = addr_r[23:16];
          low_drv.o = addr_r[7:0];
          low_drv.oe = 8'hFF;
        end else begin
          high_drv.o = addr_r[15:8];
          // data follows address on the same pins
          if (we_r && phase_r <= emb_pkg::PH_DACK) begin
            low_drv.o = wdata_r;
            low_drv.oe = 8'hFF;
          end
        end
        if (phase_r >= emb_pkg::PH_STRB_FIRST &&
            phase_r <= emb_pkg::PH_STRB_LAST) begin
          wr_c = !we_r;
          rd_c = we_r;
        end
      end
      emb_pkg::EMB_ST_IDLE: begin
        // strobe keeps running; fetch strobe stays high
        ale_c = (phase_r == emb_pkg::PH_ALE);
      end
      default: begin
        bus_en = 1'b0;
      end
    endcase
  end

  emb_port_pin u_low_pin (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .bus_en(bus_en),
    .bus_drv(low_drv),
    .latch(low_port_latch),
    .pin_o(low_addr_data_port_o),
    .pin_oe(low_addr_data_port_oe)
  );

  emb_port_pin u_high_pin (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .bus_en(bus_en),
    .bus_drv(high_drv),
    .latch(high_port_latch),
    .pin_o(high_addr_port_o),
    .pin_oe(high_addr_port_oe)
  );

  // Strobe flops; fetch strobe pin released while the strap is read
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      addr_latch_strobe <= 1'b0;
      program_fetch_strobe_n_o <= 1'b1;
      program_fetch_strobe_n_oe <= 1'b0;
      data_read_strobe_n <= 1'b1;
      data_write_strobe_n <= 1'b1;
    end else begin
      addr_latch_strobe <= ale_c;
      program_fetch_strobe_n_o <= program_fetch_strobe_n_c;
      program_fetch_strobe_n_oe <= (state_r != emb_pkg::EMB_ST_STRAP);
      data_read_strobe_n <= rd_c;
      data_write_strobe_n <= wr_c;
    end
  end

  // Sample at the last period of each strobe; pins seen two cycles late
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fetch_ack <= 1'b0;
      data_ack <= 1'b0;
      fetch_data <= emb_pkg::BYTE_RST;
      data_rdata <= emb_pkg::BYTE_RST;
      low_port_value <= emb_pkg::BYTE_RST;
      high_port_value <= emb_pkg::BYTE_RST;
    end else begin
      low_port_value <= low_s;
      high_port_value <= high_s;
      fetch_ack <= (state_r == emb_pkg::EMB_ST_FETCH) && osc_en &&
                   (phase_r == emb_pkg::PH_FETCH_LAST);
      data_ack <= (state_r == emb_pkg::EMB_ST_DATA) && osc_en &&
                  (phase_r == emb_pkg::PH_DACK);
      if ((state_r == emb_pkg::EMB_ST_FETCH) && osc_en &&
          (phase_r == emb_pkg::PH_FETCH_LAST)) begin
        fetch_data <= low_s;
      end
      if ((state_r == emb_pkg::EMB_ST_DATA) && osc_en && !we_r &&
          (phase_r == emb_pkg::PH_STRB_LAST)) begin
        data_rdata <= low_s;
      end
    end
  end

  // Helper: cycles between address strobe rises
  logic ale_q_r;
  logic ale_seen_r;
  logic [7:0] gap_r;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ale_q_r <= 1'b0;
      ale_seen_r <= 1'b0;
      gap_r <= 8'h00;
    end else begin
      ale_q_r <= addr_latch_strobe;
      if (addr_latch_strobe && !ale_q_r) begin
        ale_seen_r <= 1'b1;
        gap_r <= 8'h01;
      end else if (gap_r != 8'hFF) begin
        gap_r <= gap_r + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  bus_low_addr_a: assert property (
    (state_r == emb_pkg::EMB_ST_FETCH && phase_r <= emb_pkg::PH_ADDR_LAST)
    |=> (low_addr_data_port_oe == 8'hFF &&
         low_addr_data_port_o == $past(addr_r[7:0])))
    else $error("low port not driving address");

  idle_float_a: assert property (
    (state_r == emb_pkg::EMB_ST_IDLE)
    |=> (low_addr_data_port_oe == ~$past(low_port_latch)))
    else $error("idle low port enable wrong");

  high_addr_a: assert property (
    (state_r == emb_pkg::EMB_ST_FETCH)
    |=> (high_addr_port_oe == 8'hFF &&
         high_addr_port_o == $past(addr_r[15:8])))
    else $error("high port not driving fetch address");

  page_latch_a: assert property (
    (state_r == emb_pkg::EMB_ST_DATA && phase_r == emb_pkg::PH_ALE)
    |=> (addr_latch_strobe && high_addr_port_o == $past(addr_r[23:16])))
    else $error("page byte missing under address strobe");

  ale_period_a: assert property (
    (addr_latch_strobe && !ale_q_r && ale_seen_r)
    |-> (gap_r == 8'(6 * OSC_DIV) || gap_r == 8'(12 * OSC_DIV)))
    else $error("address strobe period wrong");

  fetch_strobe_a: assert property (
    (state_r == emb_pkg::EMB_ST_FETCH && phase_r == emb_pkg::PH_FETCH_FIRST)
    |=> (!program_fetch_strobe_n_o && low_addr_data_port_oe == 8'h00))
    else $error("fetch strobe not gating bus");

  program_fetch_strobe_n_high_a: assert property (
    (state_r != emb_pkg::EMB_ST_FETCH) |=> program_fetch_strobe_n_o)
    else $error("fetch strobe low outside fetch");

  strap_release_a: assert property (
    (state_r == emb_pkg::EMB_ST_STRAP && strap_cnt_r == emb_pkg::STRAP_LAST)
    |=> (download_mode == !$past(program_fetch_strobe_n_s)) ##1 program_fetch_strobe_n_oe)
    else $error("download strap not captured");

  int_code_a: assert property (
    (ea_s && fetch_addr <= emb_pkg::INT_CODE_TOP && slot_end && !data_req)
    |=> (state_r == emb_pkg::EMB_ST_IDLE))
    else $error("internal code fetched externally");

  write_strobe_a: assert property (
    !data_write_strobe_n |-> (low_addr_data_port_oe == 8'hFF &&
                              low_addr_data_port_o == wdata_r &&
                              data_read_strobe_n))
    else $error("write strobe without data on bus");

  read_strobe_a: assert property (
    !data_read_strobe_n |-> (low_addr_data_port_oe == 8'h00 &&
                             data_write_strobe_n && !addr_latch_strobe))
    else $error("read strobe while bus driven");

  fetch_done_c: cover property (fetch_req ##[1:40] fetch_ack);
  data_write_c: cover property (!data_write_strobe_n ##[1:40] data_ack);
  data_read_c: cover property (!data_read_strobe_n ##[1:40] data_ack);
  download_c: cover property (download_mode);

endmodule

// ### verilog/emb_pkg.sv
// Constants, carrier types and states for the external memory bus block
// Notes on behaviour
// - Low port multiplexes address then data, strong ones
// - Idle low port floats where latch holds one
// - High port drives upper address bytes
// - Address strobe latches low byte and page
// - Address strobe every six periods, not data
// - Fetch strobe gates external code once per fetch slot
// - Fetch strobe high during internal execution
// - Fetch strobe pulled low at reset: download
// - Select high: internal code up to 1FFF
// - Write strobe makes memory latch low port
// - Read strobe lets memory drive low port
package emb_pkg;

  // Oscillator periods per bus slot
  localparam int unsigned OSC_PER_SLOT = 6;
  localparam int unsigned OSC_PER_DATA = 12;
  // Clock cycles per oscillator period, and its legal range
  localparam int unsigned OSC_DIV_DEF = 2;
  localparam int unsigned OSC_DIV_MIN = 2;
  localparam int unsigned OSC_DIV_MAX = 16;
  // Clock cycles the fetch strobe pin settles before strap capture
  localparam logic [2:0] STRAP_LAST = 3'h3;

  // Phase numbers inside a slot, one per oscillator period
  localparam logic [3:0] PH_ALE = 4'h0;
  localparam logic [3:0] PH_ADDR_LAST = 4'h1;
  localparam logic [3:0] PH_FETCH_FIRST = 4'h2;
  localparam logic [3:0] PH_FETCH_LAST = 4'h4;
  localparam logic [3:0] PH_SLOT_LAST = 4'h5;
  localparam logic [3:0] PH_STRB_FIRST = 4'h3;
  localparam logic [3:0] PH_STRB_LAST = 4'h9;
  localparam logic [3:0] PH_DACK = 4'hA;
  localparam logic [3:0] PH_DATA_LAST = 4'hB;

  // Highest internal code address while the select input is high
  localparam logic [15:0] INT_CODE_TOP = 16'h1FFF;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [23:0] ADDR_RST = 24'h000000;

  // One data memory request
  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [7:0] wdata;
  } emb_data_cmd_t;

  // Bus-mode drive of one eight-pin port
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } emb_port_drv_t;

  // Slot kinds, one-hot
  typedef enum logic [3:0] {
    EMB_ST_STRAP = 4'h1,
    EMB_ST_IDLE = 4'h2,
    EMB_ST_FETCH = 4'h4,
    EMB_ST_DATA = 4'h8
  } emb_state_t;

endpackage

// ### verilog/emb_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module emb_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ### verilog/emb_port_pin.sv
// Output stage of one eight-pin port, bus use or open-drain latch use
`timescale 1ns/100ps
module emb_port_pin (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic bus_en,
  input emb_pkg::emb_port_drv_t bus_drv,
  input wire logic [7:0] latch,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe
);

  // Registered so every pin changes on the same edge as the strobes
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pin_o <= emb_pkg::BYTE_RST;
      pin_oe <= emb_pkg::BYTE_RST;
    end else if (bus_en) begin
      pin_o <= bus_drv.o;
      pin_oe <= bus_drv.oe;
    end else begin
      pin_o <= emb_pkg::BYTE_RST;
      pin_oe <= ~latch;
    end
  end

endmodule

// ### testbench/emb_ext_mem.sv
// External code and data memory with its address latch
`timescale 1ns/100ps
module emb_ext_mem (
  input wire logic ale,
  input wire logic program_fetch_strobe_n_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] p0,
  input wire logic [7:0] p2,
  input wire logic [7:0] lag,
  output logic [7:0] drv_o,
  output logic drv_oe,
  output logic [23:0] last_addr
);
  logic [7:0] lo_r;
  logic [7:0] page_r;
  logic code_on = 1'b0;
  logic rd_on = 1'b0;
  logic [7:0] mem [int];

  always @(negedge ale) begin
    lo_r = p0;
    page_r = p2;
  end

  // code byte only after a lag, dropped at once
  always @(negedge program_fetch_strobe_n_n) begin
    last_addr = {8'h00, p2, lo_r};
    #(lag) code_on = !program_fetch_strobe_n_n;
  end
  always @(posedge program_fetch_strobe_n_n) code_on = 1'b0;

  // read data only inside the strobe
  always @(negedge rd_n) begin
    last_addr = {page_r, p2, lo_r};
    #(lag) rd_on = !rd_n;
  end
  always @(posedge rd_n) rd_on = 1'b0;

  // byte captured as the strobe ends
  always @(posedge wr_n) begin
    if ($time > 0) begin
      last_addr = {page_r, p2, lo_r};
      mem[last_addr] = p0;
    end
  end

  // Idle output is don't-care: the pull-ups win when not enabled
  always @* begin
    drv_oe = code_on | rd_on;
    drv_o = code_on ? (lo_r ^ p2 ^ 8'h5A) :
      (mem.exists(last_addr) ? mem[last_addr] : 8'h00);
  end
endmodule

// ### testbench/test_ext_memory_bus_interface.sv
// Self-checking bench for the external memory bus controller
`timescale 1ns/100ps
module test_ext_memory_bus_interface;
  logic clk_sys = 1'b0;
  logic nrst, sel_n, fetch_req, data_req, strap;
  logic [15:0] fetch_addr;
  emb_pkg::emb_data_cmd_t data_cmd;
  logic [7:0] lp_latch, hp_latch, lag, fetch_data, data_rdata, lp_val, hp_val;
  logic code_ext, fetch_ack, data_ack, dl_mode, ps_o, ps_oe, ale, rd_n, wr_n;
  logic [7:0] p0_o, p0_oe, p2_o, p2_oe, mem_o;
  logic mem_oe;
  logic [23:0] mem_addr;
  wire [7:0] p0_w = (p0_oe & p0_o) | (~p0_oe & (mem_oe ? mem_o : 8'hFF));
  wire [7:0] p2_w = (p2_oe & p2_o) | ~p2_oe;
  wire ps_w = ps_oe ? ps_o : strap;
  integer error_cnt = 0, tests_run = 0, seed, i, c;
  integer cyc = 0, ale_last = 0, ale_gap = 0, ps_low = 0, ale_bad = 0;
  logic ale_d = 1'b0;
  logic [31:0] r;
  logic [7:0] shadow [int];
  logic [23:0] aq [$];

  always #10 clk_sys = ~clk_sys;

  emb_bus_ctrl #(.OSC_DIV(2)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
    .external_code_select_n(sel_n), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .code_ext(code_ext), .fetch_ack(fetch_ack),
    .fetch_data(fetch_data), .data_req(data_req), .data_cmd(data_cmd),
    .data_ack(data_ack), .data_rdata(data_rdata),
    .low_port_latch(lp_latch), .high_port_latch(hp_latch),
    .low_port_value(lp_val), .high_port_value(hp_val),
    .download_mode(dl_mode), .low_addr_data_port_i(p0_w),
    .low_addr_data_port_o(p0_o), .low_addr_data_port_oe(p0_oe),
    .high_addr_port_i(p2_w), .high_addr_port_o(p2_o),
    .high_addr_port_oe(p2_oe), .program_fetch_strobe_n_i(ps_w),
    .program_fetch_strobe_n_o(ps_o), .program_fetch_strobe_n_oe(ps_oe),
    .addr_latch_strobe(ale), .data_read_strobe_n(rd_n),
    .data_write_strobe_n(wr_n));

  emb_ext_mem mem_u (.ale(ale), .program_fetch_strobe_n_n(ps_w), .rd_n(rd_n), .wr_n(wr_n),
    .p0(p0_w), .p2(p2_w), .lag(lag), .drv_o(mem_o), .drv_oe(mem_oe),
    .last_addr(mem_addr));

  // Strobe monitors: spacing, fetch strobe lows, strobe overlap
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    ale_d <= ale;
    if (ale && !ale_d) begin
      ale_gap <= cyc - ale_last;
      ale_last <= cyc;
    end
    if (!ps_w) ps_low <= ps_low + 1;
    if (ale && (!rd_n || !wr_n)) ale_bad <= ale_bad + 1;
  end

  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Strap level must stand from release until the strobe is driven
  task automatic do_reset(input logic pull);
    strap = pull;
    nrst = 1'b0;
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (20) @(negedge clk_sys);
  endtask

  task automatic fetch(input logic [15:0] a);
    integer n;
    fetch_req = 1'b1;
    fetch_addr = a;
    for (n = 0; n < 200 && fetch_ack !== 1'b1; n++) @(negedge clk_sys);
    fetch_req = 1'b0;
    check("fetch_ack", 24'(fetch_ack), 24'h1);
    check("fetch_data", 24'(fetch_data), 24'(a[7:0] ^ a[15:8] ^ 8'h5A));
    check("fetch_pins", mem_addr, {8'h00, a});
    @(negedge clk_sys);
  endtask

  task automatic xfer(input logic we, input logic [23:0] a,
                      input logic [7:0] d);
    integer n;
    data_cmd = {we, a, d};
    data_req = 1'b1;
    for (n = 0; n < 300 && data_ack !== 1'b1; n++) @(negedge clk_sys);
    data_req = 1'b0;
    check("data_ack", 24'(data_ack), 24'h1);
    check("data_pins", mem_addr, a);
    if (we)
      shadow[a] = d;
    else
      check("data_rdata", 24'(data_rdata), 24'(shadow[a]));
    @(negedge clk_sys);
  endtask

  // Cut a hang short well past the expected run length
  initial begin
    #200000;
    error_cnt++;
    wrap_up;
  end

  initial begin
    seed = 44;
    nrst = 1'b0;
    sel_n = 1'b1;
    fetch_req = 1'b0;
    fetch_addr = 16'h0000;
    data_req = 1'b0;
    data_cmd = '0;
    lp_latch = 8'hFF;
    hp_latch = 8'hFF;
    lag = 8'h05;
    strap = 1'b0;
    @(negedge clk_sys);
    do_reset(1'b0);
    check("download_low", 24'(dl_mode), 24'h1);
    do_reset(1'b1);
    check("download_high", 24'(dl_mode), 24'h0);
    // Idle ports follow their latches
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      lp_latch = r[7:0];
      hp_latch = r[15:8];
      repeat (8) @(negedge clk_sys);
      // Invert at eight bits; a cast would widen first and set the top
      check("p0_oe", 24'(p0_oe), {16'h0000, ~lp_latch});
      check("p0_level", 24'(lp_val), 24'(lp_latch));
      check("p2_level", 24'(hp_val), 24'(hp_latch));
    end
    check("ale_gap", 24'(ale_gap), 24'h00000C);
    // Internal code: request never taken, fetch strobe stays high
    c = ps_low;
    fetch_addr = 16'h1FFF;
    fetch_req = 1'b1;
    repeat (60) @(negedge clk_sys);
    check("code_ext_int", 24'(code_ext), 24'h0);
    check("int_program_fetch_strobe_n", 24'(ps_low - c), 24'h0);
    fetch_req = 1'b0;
    @(negedge clk_sys);
    fetch_addr = 16'h2000;
    @(negedge clk_sys);
    check("code_ext_top", 24'(code_ext), 24'h1);
    sel_n = 1'b0;
    fetch_addr = 16'h0000;
    repeat (4) @(negedge clk_sys);
    check("code_ext_sel", 24'(code_ext), 24'h1);
    // Back-to-back fetches, prompt then slow memory
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      lag = (i < 4) ? 8'h05 : 8'h2D;
      fetch((i == 0) ? 16'hFFFF : r[15:0]);
    end
    sel_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    c = ps_low;
    // Writes then reads, read-after-write at the same place first
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      aq.push_front(r[23:0]);
      xfer(1'b1, r[23:0], r[31:24]);
    end
    for (i = 0; i < 4; i++) begin
      lag = i[0] ? 8'h05 : 8'h64;
      xfer(1'b0, aq.pop_front(), 8'h00);
    end
    check("data_program_fetch_strobe_n", 24'(ps_low - c), 24'h0);
    check("ale_in_strobe", 24'(ale_bad), 24'h0);
    wrap_up;
  end
endmodule
